/* File: verilog/lane_conditioning_regs.v */
// lane conditioning register slice behind the management serial interface
//
// Summary of operation
// [R1] equalizer field: bit 5 enable, bits 4:3 gain stage, bits 2:0 boost.
// [R2] equalizer register resets to 20h, the bypass code.
// [R3] twenty-four settings: three gain stages times eight boost levels.
// [R4] idle select bit 5 set: automatic idle detect mutes; clear: bit 4.
// [R5] manual: bit 4 clear drives output, detect off; set forces idle.
// [R6] threshold bits 3:2 de-assert, bits 1:0 assert level, default 00.
// [R7] swing one seven-bit code: 03h default, 07h, 0Fh higher, 1Fh/3Fh open.
// [R8] swing two is a full eight-bit type plus level field.
// [R9] fields read back last write and return to defaults on reset.
`timescale 1ns/1ps
`default_nettype none
`include "lane_cond_map.vh"

module lane_conditioning_regs #(
    parameter [6:0] SLAVE_ADDR = `DEF_SLAVE_ADDR
) (
    // clock and reset
    input  wire       SYS_CLK,
    input  wire       RST_B,
    // management serial interface, open-drain data
    input  wire       SCL_IN,
    input  wire       SDA_IN,
    output wire       SDA_OUT,
    output wire       SDA_OE,
    // idle detector of the input feeding side_a_output_lane_zero
    input  wire       IDLE_DETECTED,
    // common_input_lane_zero equalizer
    output wire       EQ_ENABLE,
    output wire [1:0] GAIN_STAGE_SELECT,
    output wire [2:0] BOOST_LEVEL_SELECT,
    output wire       EQ_BOOST_ACTIVE,
    // side_b_input_lane_one idle thresholds
    output wire [1:0] IDLE_DEASSERT_LEVEL,
    output wire [1:0] IDLE_ASSERT_LEVEL,
    // side_a_output_lane_zero driver
    output wire       OUTPUT_MUTE,
    output wire       SIGNAL_DETECT_ENABLE,
    output wire [6:0] SIDE_A_SWING_ONE,
    output wire [7:0] SIDE_A_SWING_TWO,
    // common_output_lane_one driver
    output wire [6:0] COMMON_SWING_ONE,
    output wire [7:0] COMMON_SWING_TWO
);

    // protocol states
    localparam [3:0] ST_IDLE   = 4'h0;
    localparam [3:0] ST_ADDR   = 4'h1;
    localparam [3:0] ST_ACK_A  = 4'h2;
    localparam [3:0] ST_CMD    = 4'h3;
    localparam [3:0] ST_ACK_C  = 4'h4;
    localparam [3:0] ST_WDATA  = 4'h5;
    localparam [3:0] ST_ACK_W  = 4'h6;
    localparam [3:0] ST_RDATA  = 4'h7;
    localparam [3:0] ST_ACK_R  = 4'h8;

    // register storage
    reg [7:0] b_swing_one;
    reg [7:0] b_swing_two;
    reg [7:0] c_idle_thresh;
    reg [7:0] d_idle_select;
    reg [7:0] e_eq_ctrl;
    reg [7:0] d_swing_one;
    reg [7:0] d_swing_two;

    // protocol engine state
    reg [3:0] state;
    reg [3:0] bit_cnt;
    reg [7:0] shift;
    reg [7:0] pointer;
    reg       read_mode;
    reg       master_nack;
    reg       sda_oe;
    reg       sda_out;

    // derived driver controls and equalizer boost flag
    reg       mute;
    reg       detect_en;
    reg       boost_active;

    // synchroniser outputs, current and previous samples
    wire [2:0] sync_now;
    wire [2:0] sync_prev;

    // pins enter through two flops before any use
    pin_sync #(
        .WIDTH     (3)
    ) u_pin_sync (
        .clk       (SYS_CLK),
        .rst_b     (RST_B),
        .async_in  ({IDLE_DETECTED, SDA_IN, SCL_IN}),
        .sync_out  (sync_now),
        .sync_last (sync_prev)
    );

    // synchronised levels; start and stop need the clock line high
    wire scl      = sync_now[0];
    wire sda      = sync_now[1];
    wire idle_in  = sync_now[2];
    wire scl_rise = sync_now[0] & ~sync_prev[0];
    wire scl_fall = ~sync_now[0] & sync_prev[0];
    wire start_ev = scl & sync_prev[0] & ~sync_now[1] & sync_prev[1];
    wire stop_ev  = scl & sync_prev[0] & sync_now[1] & ~sync_prev[1];

    // read decode, unmapped offsets read as zero
    function [7:0] read_reg;
        input [7:0] ofs;
        begin
            case (ofs)
                `OFS_B_SWING_ONE:   read_reg = b_swing_one;   // R9
                `OFS_B_SWING_TWO:   read_reg = b_swing_two;
                `OFS_C_IDLE_THRESH: read_reg = c_idle_thresh;
                `OFS_D_IDLE_SELECT: read_reg = d_idle_select;
                `OFS_E_EQ_CTRL:     read_reg = e_eq_ctrl;
                `OFS_D_SWING_ONE:   read_reg = d_swing_one;
                `OFS_D_SWING_TWO:   read_reg = d_swing_two;
                default:            read_reg = 8'h00;
            endcase
        end
    endfunction

    // contents of the register the pointer names
    wire [7:0] rd_now = read_reg(pointer);

    // serial protocol engine and register writes
    always @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            state         <= ST_IDLE;
            bit_cnt       <= 4'h0;
            shift         <= 8'h00;
            pointer       <= 8'h00;
            read_mode     <= 1'b0;
            master_nack   <= 1'b0;
            sda_oe        <= 1'b0;
            sda_out       <= 1'b0;
            // register defaults
            b_swing_one   <= `RST_SWING_ONE;     // R7
            b_swing_two   <= `RST_SWING_TWO;     // R8
            c_idle_thresh <= `RST_IDLE_THRESH;   // R6
            d_idle_select <= `RST_IDLE_SELECT;   // R4
            e_eq_ctrl     <= `RST_EQ_CTRL;       // R2
            d_swing_one   <= `RST_SWING_ONE;     // R7
            d_swing_two   <= `RST_SWING_TWO;     // R9
        end else if (stop_ev) begin
            state   <= ST_IDLE;
            sda_oe  <= 1'b0;
            bit_cnt <= 4'h0;
        end else if (start_ev) begin
            state   <= ST_ADDR;
            sda_oe  <= 1'b0;
            bit_cnt <= 4'h0;
        end else begin
            case (state)
                ST_ADDR, ST_CMD, ST_WDATA: begin
                    if (scl_rise && bit_cnt != 4'h8) begin
                        shift   <= {shift[6:0], sda};
                        bit_cnt <= bit_cnt + 4'h1;
                    end else if (scl_fall && bit_cnt == 4'h8) begin
                        bit_cnt <= 4'h0;
                        if (state == ST_ADDR) begin
                            if (shift[7:1] == SLAVE_ADDR) begin
                                read_mode <= shift[0];
                                sda_oe    <= 1'b1;
                                state     <= ST_ACK_A;
                            end else begin
                                // another device addressed: keep off
                                state <= ST_IDLE;
                            end
                        end else if (state == ST_CMD) begin
                            // command byte selects the register
                            pointer <= shift;
                            sda_oe  <= 1'b1;
                            state   <= ST_ACK_C;
                        end else begin
                            // store whole byte, reserved bits included
                            case (pointer)
                                `OFS_B_SWING_ONE:   b_swing_one   <= shift;
                                `OFS_B_SWING_TWO:   b_swing_two   <= shift;
                                `OFS_C_IDLE_THRESH: c_idle_thresh <= shift;
                                `OFS_D_IDLE_SELECT: d_idle_select <= shift;
                                `OFS_E_EQ_CTRL:     e_eq_ctrl     <= shift;
                                `OFS_D_SWING_ONE:   d_swing_one   <= shift;
                                `OFS_D_SWING_TWO:   d_swing_two   <= shift;
                                default:            ;
                            endcase // R9
                            pointer <= pointer + 8'h01;
                            sda_oe  <= 1'b1;
                            state   <= ST_ACK_W;
                        end
                    end
                end
                ST_ACK_A: begin
                    if (scl_fall) begin
                        if (read_mode) begin
                            // first read byte, top bit on the line
                            shift   <= rd_now;
                            pointer <= pointer + 8'h01;
                            sda_oe  <= ~rd_now[7];
                            bit_cnt <= 4'h1;
                            state   <= ST_RDATA;
                        end else begin
                            sda_oe <= 1'b0;
                            state  <= ST_CMD;
                        end
                    end
                end
                ST_ACK_C, ST_ACK_W: begin
                    if (scl_fall) begin
                        sda_oe <= 1'b0;
                        state  <= ST_WDATA;
                    end
                end
                ST_RDATA: begin
                    if (scl_fall) begin
                        if (bit_cnt == 4'h8) begin
                            sda_oe  <= 1'b0;
                            bit_cnt <= 4'h0;
                            state   <= ST_ACK_R;
                        end else begin
                            // next bit after each falling clock
                            shift   <= {shift[6:0], 1'b0};
                            sda_oe  <= ~shift[6];
                            bit_cnt <= bit_cnt + 4'h1;
                        end
                    end
                end
                ST_ACK_R: begin
                    if (scl_rise) begin
                        master_nack <= sda;
                    end else if (scl_fall) begin
                        // master nack ends the read, ack fetches more
                        if (master_nack) begin
                            state <= ST_IDLE;
                        end else begin
                            shift   <= rd_now;
                            pointer <= pointer + 8'h01;
                            sda_oe  <= ~rd_now[7];
                            bit_cnt <= 4'h1;
                            state   <= ST_RDATA;
                        end
                    end
                end
                ST_IDLE: begin
                    sda_oe <= 1'b0;
                end
                default: begin
                    state  <= ST_IDLE;
                    sda_oe <= 1'b0;
                end
            endcase
        end
    end

    // mute source and equalizer status flops
    always @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            mute         <= 1'b0;
            detect_en    <= 1'b0;
            boost_active <= 1'b0;
        end else begin
            // automatic mode follows the detector, manual the mute bit
            if (d_idle_select[`IDLE_AUTO_BIT]) begin
                mute      <= idle_in;                          // R4
                detect_en <= 1'b1;
            end else begin
                mute      <= d_idle_select[`IDLE_MUTE_BIT];    // R5
                detect_en <= 1'b0;                             // R5
            end
            // gain stage 00 with enable set is the bypass code
            boost_active <= e_eq_ctrl[`EQ_EN_BIT] &
                (e_eq_ctrl[`EQ_GAIN_HI:`EQ_GAIN_LO] != 2'b00);  // R3
        end
    end

    // equalizer fields straight from their register bits, boost flag from its flop
    assign EQ_ENABLE            = e_eq_ctrl[`EQ_EN_BIT];                 // R1
    assign GAIN_STAGE_SELECT    = e_eq_ctrl[`EQ_GAIN_HI:`EQ_GAIN_LO];    // R1
    assign BOOST_LEVEL_SELECT   = e_eq_ctrl[`EQ_BOOST_HI:`EQ_BOOST_LO];  // R3
    assign EQ_BOOST_ACTIVE      = boost_active;

    // idle detector thresholds
    assign IDLE_DEASSERT_LEVEL  =
        c_idle_thresh[`THR_DEASSERT_HI:`THR_DEASSERT_LO];              // R6
    assign IDLE_ASSERT_LEVEL    =
        c_idle_thresh[`THR_ASSERT_HI:`THR_ASSERT_LO];                  // R6

    // output driver controls
    assign OUTPUT_MUTE          = mute;
    assign SIGNAL_DETECT_ENABLE = detect_en;
    assign SIDE_A_SWING_ONE     = d_swing_one[`SWING_ONE_HI:0];        // R7
    assign SIDE_A_SWING_TWO     = d_swing_two;                         // R8
    assign COMMON_SWING_ONE     = b_swing_one[`SWING_ONE_HI:0];        // R7
    assign COMMON_SWING_TWO     = b_swing_two;                         // R8

    // serial data line, open drain
    assign SDA_OUT              = sda_out;
    assign SDA_OE               = sda_oe;

endmodule // lane_conditioning_regs

`default_nettype wire

/* File: verilog/lane_cond_map.vh */
// register offsets, field positions and reset values of the conditioning slice
`ifndef LANE_COND_MAP_VH
`define LANE_COND_MAP_VH

// register offsets on the management serial interface
`define OFS_B_SWING_ONE      8'h25
`define OFS_B_SWING_TWO      8'h26
`define OFS_C_IDLE_THRESH    8'h27
`define OFS_D_IDLE_SELECT    8'h2B
`define OFS_E_EQ_CTRL        8'h2C
`define OFS_D_SWING_ONE      8'h2D
`define OFS_D_SWING_TWO      8'h2E

// reset values
`define RST_SWING_ONE        8'h03
`define RST_SWING_TWO        8'h03
`define RST_IDLE_THRESH      8'h00
`define RST_IDLE_SELECT      8'h00
`define RST_EQ_CTRL          8'h20

// equalizer field positions
`define EQ_EN_BIT            5
`define EQ_GAIN_HI           4
`define EQ_GAIN_LO           3
`define EQ_BOOST_HI          2
`define EQ_BOOST_LO          0

// idle select field positions
`define IDLE_AUTO_BIT        5
`define IDLE_MUTE_BIT        4

// idle threshold field positions
`define THR_DEASSERT_HI      3
`define THR_DEASSERT_LO      2
`define THR_ASSERT_HI        1
`define THR_ASSERT_LO        0

// swing level one field top bit
`define SWING_ONE_HI         6

// default 7-bit slave address (arbitrary value)
`define DEF_SLAVE_ADDR       7'h58

`endif

/* File: verilog/pin_sync.v */
// two-flop synchroniser bank with a delayed copy for edge detection
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
    parameter WIDTH = 3
) (
    // clock and reset
    input  wire             clk,
    input  wire             rst_b,
    // asynchronous inputs
    input  wire [WIDTH-1:0] async_in,
    // synchronised level and its previous value
    output wire [WIDTH-1:0] sync_out,
    output wire [WIDTH-1:0] sync_last
);

    reg [WIDTH-1:0] stage_one;
    reg [WIDTH-1:0] stage_two;
    reg [WIDTH-1:0] stage_three;

    genvar i;
    // one chain per input; stage_one feeds stage_two only
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_chain
            always @(posedge clk or negedge rst_b) begin
                if (!rst_b) begin
                    stage_one[i]   <= 1'b1;
                    stage_two[i]   <= 1'b1;
                    stage_three[i] <= 1'b1;
                end else begin
                    stage_one[i]   <= async_in[i];
                    stage_two[i]   <= stage_one[i];
                    stage_three[i] <= stage_two[i];
                end
            end
        end
    endgenerate

    assign sync_out  = stage_two;
    assign sync_last = stage_three;

endmodule // pin_sync

`default_nettype wire

/* File: test/lane_cond_checker.sv */
// port-level checks of the lane conditioning register slice
`timescale 1ns/1ps
`default_nettype none
module lane_cond_checker (
    // clock and reset
    input wire       SYS_CLK,
    input wire       RST_B,
    // serial bus and idle detector
    input wire       SCL_IN,
    input wire       SDA_IN,
    input wire       SDA_OUT,
    input wire       SDA_OE,
    input wire       IDLE_DETECTED,
    // conditioning outputs
    input wire       EQ_ENABLE,
    input wire [1:0] GAIN_STAGE_SELECT,
    input wire [2:0] BOOST_LEVEL_SELECT,
    input wire       EQ_BOOST_ACTIVE,
    input wire [1:0] IDLE_DEASSERT_LEVEL,
    input wire [1:0] IDLE_ASSERT_LEVEL,
    input wire       OUTPUT_MUTE,
    input wire       SIGNAL_DETECT_ENABLE,
    input wire [6:0] SIDE_A_SWING_ONE,
    input wire [7:0] SIDE_A_SWING_TWO,
    input wire [6:0] COMMON_SWING_ONE,
    input wire [7:0] COMMON_SWING_TWO
);
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RST_B);

    // detector input quiet, then mode held
    sequence s_idle_settled; $stable(IDLE_DETECTED)[*5]; endsequence
    sequence s_manual_mode; !SIGNAL_DETECT_ENABLE[*2]; endsequence

    // defaults seen at the first edge after release
    a_rst_defaults: assert property ($rose(RST_B) |-> EQ_ENABLE &&
        {GAIN_STAGE_SELECT, BOOST_LEVEL_SELECT, EQ_BOOST_ACTIVE} == 6'h00
        && !OUTPUT_MUTE && !SDA_OE && SIDE_A_SWING_ONE == 7'h03)
        else $error("reset defaults wrong");
    a_boost_flag: assert property (EQ_BOOST_ACTIVE ==
        $past(EQ_ENABLE && GAIN_STAGE_SELECT != 2'b00))
        else $error("boost flag wrong");
    a_eq_on_ack: assert property ($changed({EQ_ENABLE,
        GAIN_STAGE_SELECT, BOOST_LEVEL_SELECT}) |-> $rose(SDA_OE))
        else $error("eq field moved outside a write");
    a_cfg_on_ack: assert property ($changed({IDLE_DEASSERT_LEVEL,
        IDLE_ASSERT_LEVEL, SIDE_A_SWING_ONE, SIDE_A_SWING_TWO,
        COMMON_SWING_ONE, COMMON_SWING_TWO}) |-> $rose(SDA_OE))
        else $error("config field moved outside a write");
    a_mute_auto: assert property (s_idle_settled ##0
        (SIGNAL_DETECT_ENABLE && $past(SIGNAL_DETECT_ENABLE, 3))
        |-> OUTPUT_MUTE == IDLE_DETECTED)
        else $error("auto mute not following detector");
    a_mute_manual: assert property (s_manual_mode ##0
        $changed(OUTPUT_MUTE) |-> SDA_OE)
        else $error("manual mute moved outside a write");
    a_sde_on_ack: assert property ($changed(SIGNAL_DETECT_ENABLE)
        |-> SDA_OE && $past(SDA_OE))
        else $error("detect enable moved outside a write");
    a_oe_scl_low: assert property ($changed(SDA_OE) |-> !SCL_IN &&
        !SDA_OUT) else $error("data line moved with clock high");
endmodule // lane_cond_checker
`default_nettype wire

/* File: test/tb.sv */
// self-checking bench of the lane conditioning register slice
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin \
    failures++; $display("[FAIL] %s expected %0h seen %0h", n, e, g); end end
module tb;
    localparam logic [42:0] DEF = {6'h20, 7'h00, 7'h03, 8'h03, 7'h03, 8'h03};
    logic        sys_clk = 1'b0;
    logic        rst_b = 1'b0;
    logic        scl = 1'b1;
    logic        sda_m = 1'b1;
    logic        idle_in = 1'b0;
    logic [7:0]  q;
    int          failures = 0;
    int          comparisons = 0;
    wire         sda_out, sda_oe, eq_en, bst_act, mute, sde;
    wire  [1:0]  gain, thr_de, thr_as;
    wire  [2:0]  boost;
    wire  [6:0]  a_sw1, c_sw1;
    wire  [7:0]  a_sw2, c_sw2;
    wire         sda_in = sda_m & (~sda_oe | sda_out);
    wire  [42:0] outs = {eq_en, gain, boost, bst_act, thr_de, thr_as,
                         mute, sde, a_sw1, a_sw2, c_sw1, c_sw2};

    lane_conditioning_regs #(.SLAVE_ADDR(7'h58)) i_lane_conditioning_regs (
        .SYS_CLK(sys_clk), .RST_B(rst_b), .SCL_IN(scl), .SDA_IN(sda_in),
        .SDA_OUT(sda_out), .SDA_OE(sda_oe), .IDLE_DETECTED(idle_in),
        .EQ_ENABLE(eq_en), .GAIN_STAGE_SELECT(gain),
        .BOOST_LEVEL_SELECT(boost), .EQ_BOOST_ACTIVE(bst_act),
        .IDLE_DEASSERT_LEVEL(thr_de), .IDLE_ASSERT_LEVEL(thr_as),
        .OUTPUT_MUTE(mute), .SIGNAL_DETECT_ENABLE(sde),
        .SIDE_A_SWING_ONE(a_sw1), .SIDE_A_SWING_TWO(a_sw2),
        .COMMON_SWING_ONE(c_sw1), .COMMON_SWING_TWO(c_sw2));

    // clock, and a watchdog well past the expected run
    always #50 sys_clk = ~sys_clk;
    initial begin
        repeat (60000) @(posedge sys_clk);
        failures++;
        end_of_test();
    end

    task automatic hold(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    // one bit: data set while the clock line is low, sampled at its top
    task automatic bit_x(input logic b, output logic r);
        sda_m = b;
        hold(4);
        scl = 1'b1;
        hold(6);
        r = sda_in;
        scl = 1'b0;
        hold(2);
    endtask
    // start (first=1) or stop condition
    task automatic cond(input logic first);
        sda_m = first;
        hold(4);
        scl = 1'b1;
        hold(6);
        sda_m = ~first;
        hold(6);
        if (first) begin
            scl = 1'b0;
            hold(2);
        end
    endtask
    task automatic byte_x(input logic [7:0] d, output logic [7:0] r,
                          output logic ack);
        logic nak;
        for (int i = 7; i >= 0; i--)
            bit_x(d[i], r[i]);
        bit_x(1'b1, nak);
        ack = ~nak;
    endtask
    task automatic wr(input logic [7:0] ofs, input logic [7:0] d);
        logic [7:0] r;
        logic a0, a1, a2;
        cond(1'b1);
        byte_x(8'hB0, r, a0);
        byte_x(ofs, r, a1);
        byte_x(d, r, a2);
        cond(1'b0);
        `CHK("write ack", 3'b111, {a0, a1, a2})
    endtask
    // pointer write, repeated start, one byte read, no ack
    task automatic rchk(input logic [7:0] ofs, input logic [7:0] e);
        logic a0, a1, a2, a3;
        cond(1'b1);
        byte_x(8'hB0, q, a0);
        byte_x(ofs, q, a1);
        cond(1'b1);
        byte_x(8'hB1, q, a2);
        byte_x(8'hFF, q, a3);
        cond(1'b0);
        `CHK("read ack", 4'b1110, {a0, a1, a2, a3})
        `CHK("readback", e, q)
    endtask

    task automatic t_defaults();
        logic [55:0] ofs = 56'h25_26_27_2B_2C_2D_2E;
        logic [55:0] dfl = 56'h03_03_00_00_20_03_03;
        `CHK("reset outputs", DEF, outs)
        for (int i = 0; i < 7; i++)
            rchk(ofs[55-8*i -: 8], dfl[55-8*i -: 8]);
        $display("test defaults done");
    endtask
    task automatic t_eq();
        logic [5:0] code;
        for (int g = 1; g < 4; g++)
            for (int b = 0; b < 8; b++) begin
                code = {1'b1, g[1:0], b[2:0]};
                wr(8'h2C, {2'b00, code});
                `CHK("eq fields", code, {eq_en, gain, boost})
                `CHK("eq boost", 1'b1, bst_act)
            end
        wr(8'h2C, 8'h20);
        `CHK("bypass", 7'h40, {eq_en, gain, boost, bst_act})
        wr(8'h2C, 8'h1A);
        `CHK("eq off", 7'h34, {eq_en, gain, boost, bst_act})
        $display("test equalizer done");
    endtask
    task automatic t_thresh();
        for (int k = 0; k < 4; k++) begin
            wr(8'h27, {4'h0, k[1:0], ~k[1:0]});
            `CHK("threshold", {k[1:0], ~k[1:0]}, {thr_de, thr_as})
        end
        rchk(8'h27, 8'h0C);
        $display("test threshold done");
    endtask
    task automatic t_idle();
        idle_in = 1'b1;
        wr(8'h2B, 8'h10);
        `CHK("manual mute", 2'b10, {mute, sde})
        wr(8'h2B, 8'h00);
        `CHK("manual drive", 2'b00, {mute, sde})
        wr(8'h2B, 8'h20);
        `CHK("auto idle", 2'b11, {mute, sde})
        idle_in = 1'b0;
        hold(5);
        `CHK("auto active", 2'b01, {mute, sde})
        wr(8'h2B, 8'h30);
        `CHK("auto over bit", 2'b01, {mute, sde})
        $display("test idle select done");
    endtask
    task automatic t_swing();
        logic [39:0] codes = 40'h03_07_0F_1F_3F;
        for (int i = 0; i < 5; i++) begin
            wr(8'h2D, codes[39-8*i -: 8]);
            `CHK("swing one", codes[38-8*i -: 7], a_sw1)
        end
        wr(8'h2E, 8'h01);
        wr(8'h25, 8'h0F);
        wr(8'h26, 8'h01);
        `CHK("swings", 23'h00_8F01, {a_sw2, c_sw1, c_sw2})
        rchk(8'h2E, 8'h01);
        $display("test swing done");
    endtask
    // two-byte write, then two-byte read with a master ack between
    task automatic t_burst();
        logic [7:0] r0, r1;
        logic [4:0] a;
        cond(1'b1);
        byte_x(8'hB0, q, a[0]);
        byte_x(8'h2D, q, a[1]);
        byte_x(8'h0F, q, a[2]);
        byte_x(8'h05, q, a[3]);
        cond(1'b0);
        `CHK("burst write", 20'hF0F05, {a[3:0], 1'b0, a_sw1, a_sw2})
        cond(1'b1);
        byte_x(8'hB0, q, a[0]);
        byte_x(8'h2D, q, a[1]);
        cond(1'b1);
        byte_x(8'hB1, q, a[2]);
        for (int i = 7; i >= 0; i--)
            bit_x(1'b1, r0[i]);
        bit_x(1'b0, a[3]);
        byte_x(8'hFF, r1, a[4]);
        cond(1'b0);
        `CHK("burst read", 21'h070F05, {a, r0, r1})
        $display("test burst done");
    endtask
    // unmapped place, reserved bits, foreign address, reset mid-run
    task automatic t_odd();
        logic a;
        wr(8'h28, 8'hFF);
        rchk(8'h28, 8'h00);
        wr(8'h2C, 8'hEA);
        rchk(8'h2C, 8'hEA);
        `CHK("eq code", 6'h2A, {eq_en, gain, boost})
        cond(1'b1);
        byte_x(8'hA0, q, a);
        cond(1'b0);
        `CHK("foreign address", 1'b0, a)
        rst_b = 1'b0;
        hold(2);
        `CHK("outputs in reset", DEF, outs)
        rst_b = 1'b1;
        hold(3);
        rchk(8'h2C, 8'h20);
        $display("test odd cases done");
    endtask

    task automatic end_of_test();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // main sequence
    initial begin
        hold(2);
        rst_b = 1'b1;
        hold(3);
        t_defaults();
        t_eq();
        t_thresh();
        t_idle();
        t_swing();
        t_burst();
        t_odd();
        end_of_test();
    end
endmodule // tb

bind lane_conditioning_regs lane_cond_checker i_lane_cond_checker (
    .SYS_CLK(SYS_CLK), .RST_B(RST_B), .SCL_IN(SCL_IN), .SDA_IN(SDA_IN),
    .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE), .IDLE_DETECTED(IDLE_DETECTED),
    .EQ_ENABLE(EQ_ENABLE), .GAIN_STAGE_SELECT(GAIN_STAGE_SELECT),
    .BOOST_LEVEL_SELECT(BOOST_LEVEL_SELECT),
    .EQ_BOOST_ACTIVE(EQ_BOOST_ACTIVE),
    .IDLE_DEASSERT_LEVEL(IDLE_DEASSERT_LEVEL),
    .IDLE_ASSERT_LEVEL(IDLE_ASSERT_LEVEL), .OUTPUT_MUTE(OUTPUT_MUTE),
    .SIGNAL_DETECT_ENABLE(SIGNAL_DETECT_ENABLE),
    .SIDE_A_SWING_ONE(SIDE_A_SWING_ONE), .SIDE_A_SWING_TWO(SIDE_A_SWING_TWO),
    .COMMON_SWING_ONE(COMMON_SWING_ONE), .COMMON_SWING_TWO(COMMON_SWING_TWO));
`default_nettype wire
